// *** include/gpib_resp_pkg.sv ***
package gpib_resp_pkg;

  // Remote/local states
  typedef enum logic [1:0] {
    ST_LOCAL,
    ST_LOCAL_LOCK,
    ST_REMOTE,
    ST_REMOTE_LOCK
  } rl_state_t;

  // Decoded interface messages, one-cycle pulses from the bus engine
  typedef struct packed {
    logic my_listen;
    logic my_talk;
    logic unlisten;
    logic untalk;
    logic ifc;
    logic dcl;
    logic sdc;
    logic gtl;
    logic llo;
    logic get;
    logic spe;
    logic spd;
  } if_msg_t;

  // Event classes, one pending bit each
  localparam int N_CLASS = 6;
  localparam int CL_CMD_ERR = 0;
  localparam int CL_EXE_ERR = 1;
  localparam int CL_INT_ERR = 2;
  localparam int CL_SYS_EVT = 3;
  localparam int CL_EXE_WARN = 4;
  localparam int CL_DEV_STAT = 5;
  localparam logic [N_CLASS-1:0] EVT_RESET = 6'h08; // Power-on pending

  // Low and high class bytes for the serial poll answer
  localparam logic [7:0] STB_CMD_LO = 8'h61; // 97
  localparam logic [7:0] STB_CMD_HI = 8'h71; // 113
  localparam logic [7:0] STB_EXE_LO = 8'h62; // 98
  localparam logic [7:0] STB_EXE_HI = 8'h72; // 114
  localparam logic [7:0] STB_INT_LO = 8'h63; // 99
  localparam logic [7:0] STB_INT_HI = 8'h73; // 115
  localparam logic [7:0] STB_SYS_LO = 8'h41; // 65, power on
  localparam logic [7:0] STB_SYS_HI = 8'h51; // 81
  localparam logic [7:0] STB_WARN_LO = 8'h64;
  localparam logic [7:0] STB_WARN_HI = 8'h74;
  localparam logic [7:0] STB_DEV_BASE = 8'hC0; // Bits 8 and 7 plus device status
  localparam logic [7:0] STB_BUSY_BIT = 8'h10;
  localparam logic [7:0] STB_IDLE = 8'h00;

  // Rtl timeout
  localparam int CLK_HZ = 10_000_000;
  localparam int RTL_TIMEOUT_S = 10;
  localparam int RTL_TIMEOUT_CYC = CLK_HZ * RTL_TIMEOUT_S;
  localparam int RTL_CNT_W = 27;

endpackage

// *** logic/gpib_response.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpib_response #(
  parameter int RTL_TIMEOUT = gpib_resp_pkg::RTL_TIMEOUT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire gpib_resp_pkg::if_msg_t i_msg,
  input wire logic i_ren,
  input wire logic i_trig_en,
  input wire logic i_busy,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_query,
  input wire logic i_pending_cmds,
  input wire logic [gpib_resp_pkg::N_CLASS-1:0] i_evt,
  input wire logic [3:0] i_dev_status,
  input wire logic i_panel_key,
  input wire logic i_panel_done,
  input wire logic i_poll_done,
  output logic o_listen,
  output logic o_talk,
  output logic o_addressed_led,
  output logic o_remote_led,
  output gpib_resp_pkg::rl_state_t o_rl_state,
  output logic o_clear,
  output logic o_trigger,
  output logic o_cmd_exec,
  output logic o_cmd_error,
  output logic o_rtl,
  output logic o_rtl_error,
  output logic o_poll_mode,
  output logic o_talk_data,
  output logic o_srq,
  output logic [7:0] o_stb
);
  import gpib_resp_pkg::*;

  logic ren_s;
  logic rtl_act;
  logic get_ok;
  logic get_bad;
  logic dev_clear;
  logic rtl_start;
  logic [N_CLASS-1:0] evt_reg;
  logic [N_CLASS-1:0] evt_next;
  logic [N_CLASS-1:0] top_sel;
  logic [7:0] stb_next;
  rl_state_t st_reg;
  rl_state_t st_next;

  // Remote enable is a bus line, synchronised first
  sync2 u_ren_sync (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_d(i_ren),
    .o_q(ren_s)
  );

  // Rtl only from setting-changing keys and never in remote-lockout
  assign rtl_start = i_panel_key && (st_reg != ST_REMOTE_LOCK);

  rtl_timer #(
    .TIMEOUT_CYC(RTL_TIMEOUT)
  ) u_rtl (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_start(rtl_start),
    .i_stop(i_panel_done),
    .o_active(rtl_act)
  );

  // Listener address state
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_listen <= 1'b0;
    end else if (i_ce) begin
      if (i_msg.ifc || i_msg.unlisten) begin
        o_listen <= 1'b0;
      end else if (i_msg.my_listen) begin
        o_listen <= 1'b1;
      end
    end
  end

  // Talker address state; own listen address does not untalk
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_talk <= 1'b0;
    end else if (i_ce) begin
      if (i_msg.ifc || i_msg.untalk) begin
        o_talk <= 1'b0;
      end else if (i_msg.my_talk) begin
        o_talk <= 1'b1;
      end
    end
  end

  // Lamp follows next address state so it never lags a cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addressed_led <= 1'b0;
    end else if (i_ce) begin
      if (i_msg.ifc) begin
        o_addressed_led <= 1'b0;
      end else begin
        // Unlisten beats own listen address, so the lamp must agree
        o_addressed_led <= ((o_listen || i_msg.my_listen) && !i_msg.unlisten)
          || ((o_talk || i_msg.my_talk) && !i_msg.untalk);
      end
    end
  end

  // Serial poll mode; no data output while talked
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_poll_mode <= 1'b0;
    end else if (i_ce) begin
      if (i_msg.spd || i_msg.ifc) begin
        o_poll_mode <= 1'b0;
      end else if (i_msg.spe) begin
        o_poll_mode <= 1'b1;
      end
    end
  end

  // Buffer data only when talked and not polling; built from the next
  // talker and poll states so it moves on the same edge as they do
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_talk_data <= 1'b0;
    end else if (i_ce) begin
      o_talk_data <= (o_talk || i_msg.my_talk) && !i_msg.untalk
        && !i_msg.ifc
        && !((o_poll_mode || i_msg.spe) && !i_msg.spd);
    end
  end

  // Remote/local next state; rem enable low dominates
  always_comb begin
    st_next = st_reg;
    if (!ren_s) begin
      st_next = ST_LOCAL;
    end else begin
      unique case (st_reg)
        ST_LOCAL: begin
          if (i_msg.llo) begin
            st_next = ST_LOCAL_LOCK;
          end else if (i_msg.my_listen && !rtl_act) begin
            st_next = ST_REMOTE;
          end
        end
        ST_LOCAL_LOCK: begin
          if (i_msg.my_listen) begin
            st_next = ST_REMOTE_LOCK;
          end
        end
        ST_REMOTE: begin
          if (rtl_start) begin
            st_next = ST_LOCAL;
          end else if (i_msg.gtl && o_listen) begin
            st_next = ST_LOCAL;
          end else if (i_msg.llo) begin
            st_next = ST_REMOTE_LOCK;
          end
        end
        ST_REMOTE_LOCK: begin
          if (i_msg.gtl && o_listen) begin
            st_next = ST_LOCAL_LOCK;
          end
        end
      endcase
    end
  end

  // State register; settings live outside and are never touched here
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= ST_LOCAL;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // Exported state and remote lamp
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rl_state <= ST_LOCAL;
      o_remote_led <= 1'b0;
    end else if (i_ce) begin
      o_rl_state <= st_next;
      o_remote_led <= (st_next == ST_REMOTE)
        || (st_next == ST_REMOTE_LOCK);
    end
  end

  // Command gating uses the state latched at command start; a later
  // remote enable or go-to-local change leaves the running message alone
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cmd_exec <= 1'b0;
      o_cmd_error <= 1'b0;
    end else if (i_ce) begin
      o_cmd_exec <= 1'b0;
      o_cmd_error <= 1'b0;
      if (i_cmd_valid && o_listen) begin
        if (i_cmd_query || st_reg == ST_REMOTE
            || st_reg == ST_REMOTE_LOCK) begin
          o_cmd_exec <= 1'b1;
        end else begin
          o_cmd_error <= 1'b1;
        end
      end
    end
  end

  // Rtl output and error on unexecuted work
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rtl <= 1'b0;
      o_rtl_error <= 1'b0;
    end else if (i_ce) begin
      o_rtl <= rtl_act;
      o_rtl_error <= rtl_start && i_pending_cmds
        && (st_reg == ST_REMOTE);
    end
  end

  // Clear and trigger decisions
  assign dev_clear = i_msg.dcl || (i_msg.sdc && o_listen);
  assign get_ok = i_msg.get && o_listen && i_trig_en && !i_busy
    && (st_reg == ST_REMOTE || st_reg == ST_REMOTE_LOCK);
  assign get_bad = i_msg.get && o_listen && !get_ok;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_clear <= 1'b0;
      o_trigger <= 1'b0;
    end else if (i_ce) begin
      o_clear <= dev_clear;
      o_trigger <= get_ok;
    end
  end

  // Highest priority pending class is the one reported
  always_comb begin
    top_sel = '0;
    for (int k = N_CLASS - 1; k >= 0; k--) begin
      if (evt_reg[k]) begin
        top_sel = '0;
        top_sel[k] = 1'b1;
      end
    end
  end

  // Events: new arrivals win over clears
  always_comb begin
    evt_next = evt_reg;
    if (dev_clear) begin
      evt_next = evt_next & (N_CLASS'(1) << CL_SYS_EVT);
    end
    if (i_poll_done && o_poll_mode) begin
      evt_next = evt_next & ~top_sel;
    end
    evt_next = evt_next | i_evt;
    if (get_bad) begin
      evt_next[CL_EXE_ERR] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      evt_reg <= EVT_RESET;
    end else if (i_ce) begin
      evt_reg <= evt_next;
    end
  end

  // Class byte for the highest pending class; busy picks the high value
  always_comb begin
    stb_next = STB_DEV_BASE | {4'h0, i_dev_status};
    if (evt_next[CL_CMD_ERR]) begin
      stb_next = i_busy ? STB_CMD_HI : STB_CMD_LO;
    end else if (evt_next[CL_EXE_ERR]) begin
      stb_next = i_busy ? STB_EXE_HI : STB_EXE_LO;
    end else if (evt_next[CL_INT_ERR]) begin
      stb_next = i_busy ? STB_INT_HI : STB_INT_LO;
    end else if (evt_next[CL_SYS_EVT]) begin
      stb_next = i_busy ? STB_SYS_HI : STB_SYS_LO;
    end else if (evt_next[CL_EXE_WARN]) begin
      stb_next = i_busy ? STB_WARN_HI : STB_WARN_LO;
    end else if (evt_next[CL_DEV_STAT]) begin
      stb_next = (STB_DEV_BASE | {4'h0, i_dev_status})
        | (i_busy ? STB_BUSY_BIT : STB_IDLE);
    end
  end

  // Request held while anything pends
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_srq <= 1'b0;
      o_stb <= STB_IDLE;
    end else if (i_ce) begin
      o_srq <= |evt_next;
      o_stb <= stb_next;
    end
  end

  // Checks
  sequence s_unl;
    i_ce && i_msg.unlisten && !i_msg.my_listen;
  endsequence

  a_unl_idles: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_unl |=> !o_listen) else $error("listener not idled");
  a_unt_idles: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && i_msg.untalk && !i_msg.my_talk |=> !o_talk && !o_talk_data)
    else $error("talker not idled");
  a_led_match: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_addressed_led == (o_listen || o_talk))
    else $error("addressed lamp wrong");
  a_ifc_clears: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && i_msg.ifc |=> !o_listen && !o_talk && !o_addressed_led)
    else $error("ifc did not idle");
  a_sdc_gated: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && i_msg.sdc && !i_msg.dcl && !o_listen |=> !o_clear)
    else $error("sdc acted unaddressed");
  a_get_bad_srq: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && get_bad |=> o_srq && !o_trigger)
    else $error("bad trigger not flagged");
  a_ren_local: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && !ren_s |=> o_rl_state == ST_LOCAL && !o_remote_led)
    else $error("not local with ren false");
  a_remote_led: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_remote_led == (o_rl_state == ST_REMOTE
      || o_rl_state == ST_REMOTE_LOCK))
    else $error("remote lamp wrong");
  a_local_error: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && i_cmd_valid && o_listen && !i_cmd_query
      && st_reg == ST_LOCAL |=> o_cmd_error && !o_cmd_exec)
    else $error("local command not refused");
  a_srq_pending: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    i_ce && i_nrst |=> o_srq == (|evt_reg))
    else $error("srq not tracking events");
endmodule
`default_nettype wire

// *** logic/rtl_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtl_timer #(
  parameter int TIMEOUT_CYC = gpib_resp_pkg::RTL_TIMEOUT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_stop,
  output logic o_active
);
  import gpib_resp_pkg::*;
  logic [RTL_CNT_W-1:0] cnt_reg;
  localparam logic [RTL_CNT_W-1:0] LAST = RTL_CNT_W'(TIMEOUT_CYC - 1);

  // Hold rtl during entry; drop on execute or timeout
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_active <= 1'b0;
      cnt_reg <= '0;
    end else if (i_ce) begin
      if (i_start) begin
        o_active <= 1'b1;
        cnt_reg <= '0;
      end else if (i_stop || (o_active && cnt_reg == LAST)) begin
        o_active <= 1'b0;
        cnt_reg <= '0;
      end else if (o_active) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;

  // Two stages; first stage read only by the second
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else if (i_ce) begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** sim/ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bus controller stand-in: message pulses, remote enable, serial polls
module ctrl_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_stb,
  output var gpib_resp_pkg::if_msg_t o_msg,
  output var logic o_ren,
  output var logic o_poll_done
);
  import gpib_resp_pkg::*;

  // Quiet bus, remote enable false, until told otherwise
  initial begin
    o_msg = '0;
    o_ren = 1'b0;
    o_poll_done = 1'b0;
  end

  // One-cycle message, then the bus goes quiet again
  task automatic send(input logic [11:0] v);
    @(posedge i_mclk);
    o_msg <= if_msg_t'(v);
    @(posedge i_mclk);
    o_msg <= '0;
    #1;
  endtask

  // Level change, then room for the two-flop sync and the answer
  task automatic set_ren(input logic v);
    @(posedge i_mclk);
    o_ren <= v;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask

  // Read the status byte, then report it taken so the class clears
  task automatic poll(output logic [7:0] got);
    @(posedge i_mclk);
    got = i_stb;
    o_poll_done <= 1'b1;
    @(posedge i_mclk);
    o_poll_done <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpib_resp_pkg::*;
  localparam int RTL_T = 20;
  localparam int LIMIT = 5000; // Run needs well under a thousand cycles
  localparam logic [11:0] LSN = 12'h800, TLK = 12'h400, UNL = 12'h200;
  localparam logic [11:0] UNT = 12'h100, IFC = 12'h080, DCL = 12'h040;
  localparam logic [11:0] SDC = 12'h020, GTL = 12'h010, LLO = 12'h008;
  localparam logic [11:0] GET = 12'h004, SPE = 12'h002, SPD = 12'h001;
  logic mclk, nrst, ren, trig_en, busy, cmd_valid, cmd_query, pending;
  logic panel_key, panel_done, poll_done, listen, talk, addr_led, rem_led;
  logic clear, trigger, cmd_exec, cmd_error, rtl, rtl_error, poll_mode;
  logic talk_data, srq, ce;
  logic [N_CLASS-1:0] evt;
  logic [3:0] dev_status;
  logic [7:0] stb, b;
  if_msg_t msg;
  rl_state_t rl;
  int n_errors, total_checks, cycles, n;

  gpib_response #(.RTL_TIMEOUT(RTL_T)) i_gpib_response (
    .i_mclk(mclk), .i_nrst(nrst), .i_ce(ce), .i_msg(msg), .i_ren(ren),
    .i_trig_en(trig_en), .i_busy(busy), .i_cmd_valid(cmd_valid),
    .i_cmd_query(cmd_query), .i_pending_cmds(pending), .i_evt(evt),
    .i_dev_status(dev_status), .i_panel_key(panel_key),
    .i_panel_done(panel_done), .i_poll_done(poll_done), .o_listen(listen),
    .o_talk(talk), .o_addressed_led(addr_led), .o_remote_led(rem_led),
    .o_rl_state(rl), .o_clear(clear), .o_trigger(trigger),
    .o_cmd_exec(cmd_exec), .o_cmd_error(cmd_error), .o_rtl(rtl),
    .o_rtl_error(rtl_error), .o_poll_mode(poll_mode),
    .o_talk_data(talk_data), .o_srq(srq), .o_stb(stb));
  ctrl_model i_ctrl_model (.i_mclk(mclk), .i_stb(stb), .o_msg(msg),
    .o_ren(ren), .o_poll_done(poll_done));

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic miss(input logic [7:0] got, input logic [7:0] exp);
    n_errors++;
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
  endtask

  task automatic chkb(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) miss({7'h00, got}, {7'h00, exp});
  endtask

  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) miss(got, exp);
  endtask

  task automatic chks(input rl_state_t got, input rl_state_t exp);
    total_checks++;
    if (got !== exp) miss({6'h00, got}, {6'h00, exp});
  endtask

  task automatic tx(input logic [11:0] v);
    i_ctrl_model.send(v);
  endtask

  // Command start pulse; judged on the cycle after it stands
  task automatic cmd(input logic q, input logic ee, input logic er);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_query <= q;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
    chkb(cmd_exec, ee);
    chkb(cmd_error, er);
  endtask

  task automatic key(input logic done);
    @(posedge mclk);
    if (done) panel_done <= 1'b1;
    else panel_key <= 1'b1;
    @(posedge mclk);
    panel_key <= 1'b0;
    panel_done <= 1'b0;
    #1;
  endtask

  task automatic t_power();
    chks(rl, ST_LOCAL);
    chkb(srq, 1'b1);
    chkv(stb, STB_SYS_LO);
    tx(SPE);
    chkb(poll_mode, 1'b1);
    tx(TLK);
    chkb(talk_data, 1'b0);
    i_ctrl_model.poll(b);
    chkv(b, STB_SYS_LO);
    chkb(srq, 1'b0);
    chkv(stb, STB_DEV_BASE | {4'h0, dev_status});
    tx(SPD);
    chkb(talk_data, 1'b1);
    tx(UNT);
    chkb(talk_data, 1'b0);
    chkb(addr_led, 1'b0);
    $display("test power done");
  endtask

  task automatic t_address();
    tx(LSN);
    chkb(addr_led, 1'b1);
    tx(UNL);
    chkb(listen, 1'b0);
    chkb(addr_led, 1'b0);
    tx(LSN | TLK);
    tx(IFC);
    chkb(listen, 1'b0);
    chkb(talk, 1'b0);
    chkb(addr_led, 1'b0);
    tx(LSN | IFC);
    chkb(listen, 1'b0);
    // Clock enable low: a listen address on the bus is not taken
    @(posedge mclk);
    ce <= 1'b0;
    tx(LSN);
    chkb(listen, 1'b0);
    chkb(addr_led, 1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    #1;
    $display("test address done");
  endtask

  task automatic t_remote();
    i_ctrl_model.set_ren(1'b1);
    tx(LSN);
    chks(rl, ST_REMOTE);
    chkb(rem_led, 1'b1);
    tx(UNL);
    tx(GTL);
    chks(rl, ST_REMOTE);
    tx(LSN);
    tx(GTL);
    chks(rl, ST_LOCAL);
    chkb(rem_led, 1'b0);
    tx(LSN);
    tx(LLO);
    chks(rl, ST_REMOTE_LOCK);
    i_ctrl_model.set_ren(1'b0);
    chks(rl, ST_LOCAL);
    cmd(1'b0, 1'b0, 1'b1);
    cmd(1'b1, 1'b1, 1'b0);
    tx(LSN);
    chks(rl, ST_LOCAL);
    // Lockout cannot leave local while remote enable is false
    tx(LLO);
    chks(rl, ST_LOCAL);
    i_ctrl_model.set_ren(1'b1);
    tx(LLO);
    chks(rl, ST_LOCAL_LOCK);
    cmd(1'b0, 1'b0, 1'b1);
    tx(LSN);
    chks(rl, ST_REMOTE_LOCK);
    cmd(1'b0, 1'b1, 1'b0);
    key(1'b0);
    chks(rl, ST_REMOTE_LOCK);
    tx(UNL);
    cmd(1'b0, 1'b0, 1'b0);
    $display("test remote done");
  endtask

  task automatic t_rtl();
    i_ctrl_model.set_ren(1'b0);
    i_ctrl_model.set_ren(1'b1);
    tx(LSN);
    @(posedge mclk);
    pending <= 1'b1;
    key(1'b0);
    chks(rl, ST_LOCAL);
    chkb(rtl_error, 1'b1);
    // Rtl output trails the internal timer by one register stage
    @(posedge mclk);
    pending <= 1'b0;
    #1;
    chkb(rtl, 1'b1);
    tx(LSN);
    chks(rl, ST_LOCAL);
    n = 0;
    while (rtl === 1'b1 && n < 2 * RTL_T) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chkb(n > RTL_T / 2, 1'b1);
    tx(LSN);
    chks(rl, ST_REMOTE);
    key(1'b0);
    tx(LLO);
    tx(LSN);
    chks(rl, ST_REMOTE_LOCK);
    key(1'b1);
    @(posedge mclk);
    #1;
    chkb(rtl, 1'b0);
    $display("test rtl done");
  endtask

  task automatic t_trig();
    @(posedge mclk);
    trig_en <= 1'b1;
    tx(GET);
    chkb(trigger, 1'b1);
    trig_en <= 1'b0;
    tx(GET);
    chkb(trigger, 1'b0);
    chkv(stb, STB_EXE_LO);
    tx(DCL);
    chkb(clear, 1'b1);
    chkb(srq, 1'b0);
    busy <= 1'b1;
    trig_en <= 1'b1;
    tx(GET);
    chkb(trigger, 1'b0);
    chkv(stb, STB_EXE_HI);
    busy <= 1'b0;
    tx(UNL);
    tx(SDC);
    chkb(clear, 1'b0);
    chkb(srq, 1'b1);
    tx(LSN);
    tx(SDC);
    chkb(clear, 1'b1);
    @(posedge mclk);
    evt <= 6'h11;
    @(posedge mclk);
    evt <= '0;
    #1;
    chkv(stb, STB_CMD_LO);
    tx(SPE);
    i_ctrl_model.poll(b);
    chkb(srq, 1'b1);
    chkv(stb, STB_WARN_LO);
    i_ctrl_model.poll(b);
    chkv(b, STB_WARN_LO);
    chkb(srq, 1'b0);
    // Device status bits follow their input when nothing pends
    @(posedge mclk);
    dev_status <= 4'hA;
    @(posedge mclk);
    #1;
    chkv(stb, STB_DEV_BASE | 8'h0A);
    $display("test trigger done");
  endtask

  // Reset for eight cycles, then the scenarios in turn
  initial begin
    {mclk, nrst, trig_en, busy, cmd_valid, cmd_query, pending} = '0;
    {panel_key, panel_done, evt} = '0;
    dev_status = 4'h5;
    ce = 1'b1;
    {n_errors, total_checks, cycles} = '0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_power();
    t_address();
    t_remote();
    t_rtl();
    t_trig();
    give_verdict();
  end
endmodule
`default_nettype wire
